// ### hdl/acc_pkg.sv
// Notes on behaviour
// - axis results sign-extended to sixteen bits
// - no result data until one interface selected
// - queue head feeds results, twelve-bit resolution
// - queue advances only after full low-to-high pass
// - registers frozen between start and stop
// - status mode settles within three heartbeat transitions
// - mode codes fixed; three and four reserved
// - sleep stops clocks; standby clocks without sampling
// - watch mode detects only, jumps to run
// - run samples all axes, detection off
// - watch-and-run uses detection, pipeline, queue
// - burst takes programmed count then sleeps; a count of zero never ends
// - new-sample flag set since last status read
// - queue-empty level, set after reset
// - queue-full level at thirty-two entries
// - threshold level when count reaches threshold
// - pending bit is OR of irq flags
package acc_pkg;
  localparam int RAW_W = 14;
  localparam int Q_W = 12;
  localparam int Q_DEPTH = 32;
  localparam int LVL_W = 6;
  localparam logic [7:0] ADDR_X_LOW = 8'h02;
  localparam logic [7:0] ADDR_Z_HIGH = 8'h07;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam int ST_NEW = 3;
  localparam int ST_EMPTY = 4;
  localparam int ST_FULL = 5;
  localparam int ST_LEVEL = 6;
  localparam int ST_PEND = 7;
  localparam logic [2:0] MODE_SLEEP = 3'h0;
  localparam logic [2:0] MODE_STANDBY = 3'h1;
  localparam logic [2:0] MODE_WATCH = 3'h2;
  localparam logic [2:0] MODE_RUN = 3'h5;
  localparam logic [2:0] MODE_WATCH_RUN = 3'h6;
  localparam logic [2:0] MODE_BURST = 3'h7;
  localparam logic [7:0] BURST_FOREVER = 8'h00;
  localparam int HB_SETTLE = 3;
  localparam logic [LVL_W-1:0] LVL_ROOM = LVL_W'(Q_DEPTH - 2);
  localparam logic [LVL_W-1:0] LVL_FULL = LVL_W'(Q_DEPTH);

  typedef enum logic [2:0] {M_SLEEP, M_STANDBY, M_WATCH, M_RUN, M_WATCH_RUN, M_BURST} acc_mode_t;

  typedef struct packed {
    logic [RAW_W-1:0] x;
    logic [RAW_W-1:0] y;
    logic [RAW_W-1:0] z;
  } acc_sample_t;

  typedef struct packed {
    logic [Q_W-1:0] x;
    logic [Q_W-1:0] y;
    logic [Q_W-1:0] z;
  } acc_qword_t;
endpackage : acc_pkg

// ### hdl/acc_readout.sv
`timescale 1ns/1ps
// sample queue: flip-flop storage, ready decoded from the registered fill count so the source sees back-pressure
module acc_fifo #(
  parameter int WIDTH = 36,
  parameter int DEPTH = 32,
  parameter int LW = 6
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data,
  output logic [LW-1:0] o_level
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [LW-1:0] cnt_q;
  logic push;
  logic pop;

  assign push = i_in_valid && (cnt_q != LW'(DEPTH));
  assign pop = i_out_ready && (cnt_q != '0);
  assign o_in_ready = (cnt_q != LW'(DEPTH));
  assign o_out_valid = (cnt_q != '0);
  assign o_out_data = mem_q[rd_q];
  assign o_level = cnt_q;

  // pointers and fill count
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      if (push)
        wr_q <= wr_q + AW'(1);
      if (pop)
        rd_q <= rd_q + AW'(1);
      cnt_q <= cnt_q + LW'(push) - LW'(pop);
    end
  end

  // storage has no reset; only written words are ever read
  always_ff @(posedge i_clk)
  begin
    if (push)
      mem_q[wr_q] <= i_in_data;
  end
endmodule : acc_fifo

module acc_readout (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_heartbeat,
  input wire logic [2:0] i_if_select,
  input wire logic i_queue_en,
  input wire logic [4:0] i_queue_thresh,
  input wire logic [7:0] i_burst_count,
  input wire logic i_mode_wr,
  input wire logic [2:0] i_mode_cmd,
  input wire logic i_activity,
  input wire logic i_sample_valid,
  input wire acc_pkg::acc_sample_t i_sample,
  input wire logic [7:0] i_irq_flags,
  input wire logic i_bus_start,
  input wire logic i_bus_stop,
  input wire logic i_reg_rd,
  input wire logic [7:0] i_reg_addr,
  output logic [7:0] o_reg_rdata,
  output logic o_sample_ready,
  output logic o_clocks_on,
  output logic o_sampling_on,
  output logic o_activity_on,
  output logic o_queue_on
);
  import acc_pkg::*;

  function automatic logic [2:0] mode_code(input acc_mode_t m);
    unique case (m)
      M_SLEEP: mode_code = MODE_SLEEP;
      M_STANDBY: mode_code = MODE_STANDBY;
      M_WATCH: mode_code = MODE_WATCH;
      M_RUN: mode_code = MODE_RUN;
      M_WATCH_RUN: mode_code = MODE_WATCH_RUN;
      M_BURST: mode_code = MODE_BURST;
    endcase
  endfunction : mode_code

  function automatic logic [15:0] sext(input logic [RAW_W-1:0] v, input logic narrow);
    sext = narrow ? {{(16-Q_W){v[Q_W-1]}}, v[Q_W-1:0]} : {{(16-RAW_W){v[RAW_W-1]}}, v};
  endfunction : sext

  acc_mode_t mode_q;
  logic [2:0] hb_sync_q;
  logic hb_edge;
  logic [2:0] stat_pipe_q;
  logic [2:0] stat_mode_q;
  logic [7:0] burst_cnt_q;
  logic held_q;
  logic head_q;
  logic [2:0] pass_q;
  logic pass_done;
  logic new_data_q;
  logic [7:0] status_q;
  logic [7:0] res_q [6];
  logic [7:0] rdata_q;
  logic ready_q;
  logic take;
  logic q_path;
  logic if_ok;
  logic load_head;
  logic q_in_ready;
  logic q_out_valid;
  acc_qword_t q_in;
  acc_qword_t q_out;
  logic [LVL_W-1:0] q_level;
  logic [LVL_W-1:0] q_level_nx;
  logic q_pop;
  logic [15:0] axis_val [3];

  assign if_ok = (i_if_select != 3'h0);
  assign q_path = i_queue_en && (mode_q == M_RUN || mode_q == M_WATCH_RUN || mode_q == M_BURST);
  assign take = i_sample_valid && ready_q;
  // queue keeps the top twelve bits of each raw axis value
  assign q_in = '{x: i_sample.x[RAW_W-1 -: Q_W], y: i_sample.y[RAW_W-1 -: Q_W], z: i_sample.z[RAW_W-1 -: Q_W]};
  assign load_head = i_queue_en && !head_q && q_out_valid && !held_q && if_ok;
  // the head stays counted in the queue while the host reads it; only a full pass pops it
  assign q_pop = pass_done && head_q && i_queue_en;
  // fill level after this edge, so the registered ready can still admit the last free entry
  assign q_level_nx = q_level + LVL_W'(take && q_path && q_in_ready) - LVL_W'(q_pop && q_out_valid);
  assign hb_edge = hb_sync_q[1] ^ hb_sync_q[2];

  acc_fifo #(.WIDTH(3*Q_W), .DEPTH(Q_DEPTH), .LW(LVL_W)) u_queue (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_in_valid(take && q_path),
    .i_in_data(q_in),
    .o_in_ready(q_in_ready),
    .o_out_valid(q_out_valid),
    .i_out_ready(q_pop),
    .o_out_data(q_out),
    .o_level(q_level)
  );

  // heartbeat arrives from the oscillator domain; two flops before any edge logic
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      hb_sync_q <= 3'h0;
    else
      hb_sync_q <= {hb_sync_q[1:0], i_heartbeat};
  end

  // operating mode: host commands, auto wake from watch, burst completion
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      mode_q <= M_SLEEP;
      burst_cnt_q <= 8'h00;
    end
    else if (i_mode_wr)
    begin
      burst_cnt_q <= 8'h00;
      unique case (i_mode_cmd) // reserved codes leave the mode alone
        MODE_SLEEP: mode_q <= M_SLEEP;
        MODE_STANDBY: mode_q <= M_STANDBY;
        MODE_WATCH: mode_q <= M_WATCH;
        MODE_RUN: mode_q <= M_RUN;
        MODE_WATCH_RUN: mode_q <= M_WATCH_RUN;
        MODE_BURST: mode_q <= M_BURST;
        default: mode_q <= mode_q;
      endcase
    end
    else if (mode_q == M_WATCH && i_activity)
      mode_q <= M_RUN;
    else if (mode_q == M_BURST && take)
    begin
      burst_cnt_q <= burst_cnt_q + 8'h01;
      if (i_burst_count != BURST_FOREVER && burst_cnt_q + 8'h01 >= i_burst_count)
        mode_q <= M_SLEEP;
    end
  end

  // mode enables toward clocks, pipeline, detector and queue
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_clocks_on <= 1'b0;
      o_sampling_on <= 1'b0;
      o_activity_on <= 1'b0;
      o_queue_on <= 1'b0;
    end
    else
    begin
      o_clocks_on <= (mode_q != M_SLEEP);
      o_sampling_on <= (mode_q == M_RUN || mode_q == M_WATCH_RUN || mode_q == M_BURST);
      o_activity_on <= (mode_q == M_WATCH || mode_q == M_WATCH_RUN);
      o_queue_on <= q_path;
    end
  end

  // ready is judged on the next fill level: never overruns, yet spaced samples still fill all entries
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      ready_q <= 1'b0;
    else
      ready_q <= (mode_q == M_RUN || mode_q == M_WATCH_RUN || mode_q == M_BURST)
                 && (!q_path || q_level_nx != LVL_FULL);
  end
  assign o_sample_ready = ready_q;

  // reported mode follows the real mode by two heartbeat transitions
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      stat_pipe_q <= MODE_SLEEP;
      stat_mode_q <= MODE_SLEEP;
    end
    else if (hb_edge)
    begin
      stat_pipe_q <= mode_code(mode_q);
      stat_mode_q <= stat_pipe_q;
    end
  end

  // transaction bracket; a start in the same cycle as a stop wins
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      held_q <= 1'b0;
    else if (i_bus_start)
      held_q <= 1'b1;
    else if (i_bus_stop)
      held_q <= 1'b0;
  end

  // read pass tracking: only an in-order sweep of all six bytes counts
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      pass_q <= 3'h0;
    else if (i_reg_rd)
    begin
      if (i_reg_addr == ADDR_X_LOW)
        pass_q <= 3'h1;
      else if (pass_q != 3'h0 && i_reg_addr == ADDR_X_LOW + {5'h00, pass_q} && i_reg_addr != ADDR_Z_HIGH)
        pass_q <= pass_q + 3'h1;
      else
        pass_q <= 3'h0;
    end
  end
  assign pass_done = i_reg_rd && i_reg_addr == ADDR_Z_HIGH && pass_q == 3'h5;

  // head-in-results flag; cleared after a complete pass or when the queue is disabled
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst || !i_queue_en)
      head_q <= 1'b0;
    else if (load_head)
      head_q <= 1'b1;
    else if (pass_done)
      head_q <= 1'b0;
  end

  // sign-extended axis values from the queue head or the live sample
  generate
    for (genvar a = 0; a < 3; a++)
    begin : g_axis
      logic [RAW_W-1:0] raw;
      assign raw = (a == 0) ? (i_queue_en ? {{(RAW_W-Q_W){1'b0}}, q_out.x} : i_sample.x)
                 : (a == 1) ? (i_queue_en ? {{(RAW_W-Q_W){1'b0}}, q_out.y} : i_sample.y)
                 : (i_queue_en ? {{(RAW_W-Q_W){1'b0}}, q_out.z} : i_sample.z);
      assign axis_val[a] = sext(raw, i_queue_en);

      // result bytes frozen inside a transaction and while no interface is chosen
      always_ff @(posedge i_clk)
      begin
        if (i_sys_rst)
        begin
          res_q[2*a] <= RESULT_RESET;
          res_q[2*a+1] <= RESULT_RESET;
        end
        else if (!held_q && if_ok && (load_head || (take && !i_queue_en)))
        begin
          res_q[2*a] <= axis_val[a][7:0];
          res_q[2*a+1] <= axis_val[a][15:8];
        end
      end
    end
  endgenerate

  // new-sample flag: a fresh sample beats a clearing status read
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      new_data_q <= 1'b0;
    else if (take)
      new_data_q <= 1'b1;
    else if (i_reg_rd && i_reg_addr == ADDR_STATUS)
      new_data_q <= 1'b0;
  end

  // status snapshot; held steady during a transaction like the results
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      status_q <= STATUS_RESET | (8'h01 << ST_EMPTY);
    else if (!held_q)
    begin
      status_q[2:0] <= stat_mode_q;
      status_q[ST_NEW] <= new_data_q;
      status_q[ST_EMPTY] <= (q_level == '0);
      status_q[ST_FULL] <= (q_level == LVL_FULL);
      status_q[ST_LEVEL] <= (q_level >= {1'b0, i_queue_thresh});
      status_q[ST_PEND] <= |i_irq_flags;
    end
  end

  // register read port; unmapped addresses read zero
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
      rdata_q <= 8'h00;
    else if (i_reg_rd)
    begin
      if (i_reg_addr >= ADDR_X_LOW && i_reg_addr <= ADDR_Z_HIGH)
        rdata_q <= res_q[3'(i_reg_addr - ADDR_X_LOW)];
      else if (i_reg_addr == ADDR_STATUS)
        rdata_q <= status_q;
      else
        rdata_q <= 8'h00;
    end
  end
  assign o_reg_rdata = rdata_q;

  // heartbeat transitions spent with a stale reported mode
  logic [2:0] hb_cnt_q;
  logic [2:0] last_code_q;
  always_ff @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      hb_cnt_q <= 3'h0;
      last_code_q <= MODE_SLEEP;
    end
    else
    begin
      last_code_q <= mode_code(mode_q);
      if (mode_code(mode_q) != last_code_q || stat_mode_q == mode_code(mode_q))
        hb_cnt_q <= 3'h0;
      else if (hb_edge)
        hb_cnt_q <= hb_cnt_q + 3'h1;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);

  a_sign_ext_x: assert property (res_q[1][7:6] == {2{res_q[1][5]}})
    else $error("x high byte not sign extended");
  a_unsel_hold: assert property (i_if_select == 3'h0 |=> $stable(res_q[0]) && $stable(res_q[5]))
    else $error("results changed with no interface selected");
  a_queue_load: assert property (load_head |=> head_q && res_q[1][7:3] == {5{res_q[1][3]}})
    else $error("queue head not loaded at twelve bits");
  a_pass_advance: assert property ($fell(head_q) && $past(i_queue_en) |-> $past(pass_done))
    else $error("queue advanced without a full pass");
  a_held_stable: assert property (held_q |=> $stable(res_q[2]) && $stable(status_q))
    else $error("registers changed inside a transaction");
  a_mode_settle: assert property (hb_cnt_q < 3'(HB_SETTLE))
    else $error("reported mode stale past three transitions");
  a_mode_legal: assert property (stat_mode_q != 3'h3 && stat_mode_q != 3'h4)
    else $error("reserved mode code reported");
  a_sleep_quiet: assert property (mode_q == M_SLEEP |=> !o_clocks_on && !o_sampling_on)
    else $error("activity in sleep");
  a_watch_wake: assert property (mode_q == M_WATCH && i_activity && !i_mode_wr |=> mode_q == M_RUN ##1 !o_activity_on)
    else $error("no wake from watch mode");
  a_run_enables: assert property (mode_q == M_RUN |=> o_sampling_on && !o_activity_on)
    else $error("run mode enables wrong");
  a_burst_end: assert property (mode_q == M_BURST && take && !i_mode_wr && i_burst_count == 8'h01 |=> mode_q == M_SLEEP)
    else $error("burst did not end");
  a_new_flag: assert property (take |=> new_data_q ##1 ($past(held_q) || status_q[ST_NEW]))
    else $error("new sample flag missed");
  a_empty_lvl: assert property (!held_q && q_level == '0 |=> status_q[ST_EMPTY] && !status_q[ST_FULL])
    else $error("empty level wrong");
  a_full_lvl: assert property (!held_q |=> status_q[ST_FULL] == ($past(q_level) == LVL_FULL))
    else $error("full level wrong");
  a_thresh_lvl: assert property (!held_q |=> status_q[ST_LEVEL] == ($past(q_level) >= {1'b0, $past(i_queue_thresh)}))
    else $error("threshold level wrong");
  a_pend_or: assert property (!held_q |=> status_q[ST_PEND] == |$past(i_irq_flags))
    else $error("pending bit not OR of flags");
endmodule : acc_readout

// ### verification/acc_host_model.sv
`timescale 1ns/1ps
// host controller seen from the register port: framing pulses and single-byte reads
module acc_host_model (
  input wire logic i_clk,
  input wire logic [7:0] i_reg_rdata,
  output logic o_bus_start,
  output logic o_bus_stop,
  output logic o_reg_rd,
  output logic [7:0] o_reg_addr
);
  import acc_pkg::*;

  // idle bus: no framing, no read, address parked
  initial
  begin
    o_bus_start = 1'b0;
    o_bus_stop = 1'b0;
    o_reg_rd = 1'b0;
    o_reg_addr = 8'hFF;
  end

  // start and stop are single-cycle pulses
  task pulse_start();
    @(posedge i_clk);
    o_bus_start <= 1'b1;
    @(posedge i_clk);
    o_bus_start <= 1'b0;
  endtask : pulse_start

  task pulse_stop();
    @(posedge i_clk);
    o_bus_stop <= 1'b1;
    @(posedge i_clk);
    o_bus_stop <= 1'b0;
  endtask : pulse_stop

  // data is taken after the edge that follows the strobe
  task read_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clk);
    o_reg_rd <= 1'b1;
    o_reg_addr <= a;
    @(posedge i_clk);
    o_reg_rd <= 1'b0;
    o_reg_addr <= ~a; // released address flips so a stale decode cannot pass
    #1 d = i_reg_rdata;
  endtask : read_reg

  // whole pass, lowest address first, inside one transaction so pairs stay coherent
  task read_axes(output logic [47:0] v);
    logic [7:0] b;
    pulse_start();
    for (int i = 0; i < 6; i++)
    begin
      read_reg(ADDR_X_LOW + 8'(i), b);
      v[8*i +: 8] = b;
    end
    pulse_stop();
  endtask : read_axes
endmodule : acc_host_model

// ### verification/accel_sample_readout_status_tb_top.sv
`timescale 1ns/1ps
module accel_sample_readout_status_tb_top;
  import acc_pkg::*;
  typedef struct packed {logic [2:0] cmd; logic [2:0] mode; logic [2:0] en;} acc_row_t;
  // mode command, expected mode field, expected {clocks, sampling, activity}; reserved codes are ignored
  localparam acc_row_t ROWS [8] = '{'{3'h1, 3'h1, 3'h4}, '{3'h3, 3'h1, 3'h4}, '{3'h2, 3'h2, 3'h5},
    '{3'h5, 3'h5, 3'h6}, '{3'h6, 3'h6, 3'h7}, '{3'h7, 3'h7, 3'h6}, '{3'h0, 3'h0, 3'h0}, '{3'h4, 3'h0, 3'h0}};
  logic i_clk, i_sys_rst, i_heartbeat, i_queue_en, i_mode_wr, i_activity, i_sample_valid;
  logic i_bus_start, i_bus_stop, i_reg_rd, o_sample_ready, o_clocks_on, o_sampling_on, o_activity_on, o_queue_on;
  logic [2:0] i_if_select, i_mode_cmd;
  logic [4:0] i_queue_thresh;
  logic [7:0] i_burst_count, i_irq_flags, i_reg_addr, o_reg_rdata, st;
  logic [47:0] v;
  acc_sample_t i_sample;
  int failures, n_checks, cycles, hb_cnt;

  acc_readout acc_readout_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_heartbeat(i_heartbeat),
    .i_if_select(i_if_select), .i_queue_en(i_queue_en), .i_queue_thresh(i_queue_thresh),
    .i_burst_count(i_burst_count), .i_mode_wr(i_mode_wr), .i_mode_cmd(i_mode_cmd), .i_activity(i_activity),
    .i_sample_valid(i_sample_valid), .i_sample(i_sample), .i_irq_flags(i_irq_flags), .i_bus_start(i_bus_start),
    .i_bus_stop(i_bus_stop), .i_reg_rd(i_reg_rd), .i_reg_addr(i_reg_addr), .o_reg_rdata(o_reg_rdata),
    .o_sample_ready(o_sample_ready), .o_clocks_on(o_clocks_on), .o_sampling_on(o_sampling_on),
    .o_activity_on(o_activity_on), .o_queue_on(o_queue_on));

  acc_host_model acc_host_model_inst (.i_clk(i_clk), .i_reg_rdata(o_reg_rdata), .o_bus_start(i_bus_start),
    .o_bus_stop(i_bus_stop), .o_reg_rd(i_reg_rd), .o_reg_addr(i_reg_addr));

  // 20 MHz system clock
  initial
  begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // heartbeat toggles every 8 cycles; the cycle ceiling cuts a hang short
  always @(posedge i_clk)
  begin
    cycles <= cycles + 1;
    hb_cnt <= (hb_cnt == 7) ? 0 : hb_cnt + 1;
    if (i_sys_rst)
      i_heartbeat <= 1'b0;
    else if (hb_cnt == 7)
      i_heartbeat <= ~i_heartbeat;
    if (cycles == 30000)
    begin
      failures++;
      give_verdict();
    end
  end

  task check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED t=%0t %s seen %h exp %h", $time, msg, seen, exp);
    end
  endtask : check

  task rd(input logic [7:0] a);
    acc_host_model_inst.read_reg(a, st);
  endtask : rd

  // 40 cycles covers three heartbeat transitions plus the synchroniser
  task set_mode(input logic [2:0] c);
    @(posedge i_clk);
    i_mode_wr <= 1'b1;
    i_mode_cmd <= c;
    @(posedge i_clk);
    i_mode_wr <= 1'b0;
    repeat (40) @(posedge i_clk);
  endtask : set_mode

  // offer one sample and hold it until ready is seen at a sampling edge
  task push(input logic [13:0] sx, input logic [13:0] sy, input logic [13:0] sz);
    int k;
    k = 0;
    @(posedge i_clk);
    i_sample_valid <= 1'b1;
    i_sample <= '{x: sx, y: sy, z: sz};
    do
    begin
      @(negedge i_clk);
      k++;
    end while (o_sample_ready !== 1'b1 && k < 100);
    @(posedge i_clk);
    i_sample_valid <= 1'b0;
    i_sample <= acc_sample_t'(~{sx, sy, sz}); // stale sample never looks valid
    check(16'(k < 100), 16'h1, "sample not accepted");
  endtask : push

  task give_verdict();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : give_verdict

  // main sequence
  initial
  begin
    {i_queue_en, i_mode_wr, i_activity, i_sample_valid} = '0;
    {i_if_select, i_mode_cmd, i_queue_thresh, i_burst_count, i_irq_flags} = '0;
    i_sample = '0;
    i_sys_rst = 1'b1;
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    i_queue_thresh <= 5'h03;
    rd(ADDR_STATUS);
    check(16'(st), 16'h0010, "status after reset");
    for (int a = 2; a < 8; a++)
    begin
      rd(8'(a));
      check(16'(st), 16'(RESULT_RESET), "result reset value");
    end
    rd(8'h20);
    check(16'(st), 16'h0000, "unmapped address");
    foreach (ROWS[i])
    begin
      set_mode(ROWS[i].cmd);
      rd(ADDR_STATUS);
      check(16'(st[2:0]), 16'(ROWS[i].mode), "mode field");
      check(16'({o_clocks_on, o_sampling_on, o_activity_on}), 16'(ROWS[i].en), "mode enables");
    end
    // awkward cases: activity jump, no interface, sign, freeze, burst end, queue
    set_mode(MODE_WATCH);
    @(posedge i_clk);
    i_activity <= 1'b1;
    @(posedge i_clk);
    i_activity <= 1'b0;
    repeat (40) @(posedge i_clk);
    rd(ADDR_STATUS);
    check(16'(st[2:0]), 16'(MODE_RUN), "watch to run");
    push(14'h2001, 14'h1FFF, 14'h0005);
    acc_host_model_inst.read_axes(v);
    check(v[15:0], 16'h0000, "data without interface");
    i_if_select <= 3'h1;
    push(14'h2001, 14'h1FFF, 14'h0005);
    acc_host_model_inst.read_axes(v);
    check(v[15:0], 16'hE001, "x sign");
    check(v[31:16], 16'h1FFF, "y sign");
    check(v[47:32], 16'h0005, "z sign");
    rd(ADDR_STATUS);
    check(16'(st[ST_NEW]), 16'h1, "new flag set");
    rd(ADDR_STATUS);
    check(16'(st[ST_NEW]), 16'h0, "new flag cleared");
    acc_host_model_inst.pulse_start();
    push(14'h0123, 14'h0000, 14'h0000);
    rd(ADDR_X_LOW);
    check(16'(st), 16'h0001, "frozen in transaction");
    acc_host_model_inst.pulse_stop();
    push(14'h0456, 14'h0000, 14'h0000);
    repeat (3) @(posedge i_clk);
    rd(ADDR_X_LOW);
    check(16'(st), 16'h0056, "updates after stop");
    i_burst_count <= 8'h02;
    set_mode(MODE_BURST);
    push(14'h0001, 14'h0001, 14'h0001);
    push(14'h0002, 14'h0002, 14'h0002);
    repeat (40) @(posedge i_clk);
    rd(ADDR_STATUS);
    check(16'(st[2:0]), 16'(MODE_SLEEP), "burst ends in sleep");
    i_queue_en <= 1'b1;
    set_mode(MODE_RUN);
    check(16'(o_queue_on), 16'h1, "queue on in run");
    for (int k = 1; k < 4; k++)
      push(14'(k * 4), 14'h2000, 14'h0010);
    repeat (3) @(posedge i_clk);
    rd(ADDR_STATUS);
    check(16'(st & 8'hF0), 16'h0040, "three queued");
    acc_host_model_inst.read_axes(v);
    check(v[15:0], 16'h0001, "queue head x");
    check(v[31:16], 16'hF800, "queue head y");
    check(v[47:32], 16'h0004, "queue head z");
    acc_host_model_inst.pulse_start();
    rd(ADDR_X_LOW);
    rd(8'h03);
    acc_host_model_inst.pulse_stop();
    check(16'(st), 16'h0000, "partial pass high byte");
    acc_host_model_inst.read_axes(v);
    check(v[15:0], 16'h0002, "partial pass kept head");
    repeat (3) @(posedge i_clk);
    rd(ADDR_STATUS);
    check(16'(st & 8'hF0), 16'h0000, "below threshold");
    for (int k = 4; k < 35; k++)
      push(14'(k * 4), 14'h2000, 14'h0010);
    repeat (3) @(posedge i_clk);
    rd(ADDR_STATUS);
    check(16'(st & 8'hF0), 16'h0060, "queue full");
    check(16'(o_sample_ready), 16'h0, "full refuses");
    i_irq_flags <= 8'h04;
    repeat (3) @(posedge i_clk);
    rd(ADDR_STATUS);
    check(16'(st[ST_PEND]), 16'h1, "pending summary");
    i_irq_flags <= 8'h00;
    for (int k = 3; k < 35; k++)
    begin
      acc_host_model_inst.read_axes(v);
      check(v[15:0], 16'(k), "drain order");
    end
    repeat (3) @(posedge i_clk);
    rd(ADDR_STATUS);
    check(16'(st & 8'hF0), 16'h0010, "drained empty");
    set_mode(MODE_WATCH);
    check(16'(o_queue_on), 16'h0, "no queue in watch");
    give_verdict();
  end
endmodule : accel_sample_readout_status_tb_top
